// ---- logic/cic_defs.vh ----
// Constants of the cascaded interrupt controller
`ifndef CIC_DEFS_VH
`define CIC_DEFS_VH

// Controller shape
`define CIC_UNIT_CHANNELS  8
`define CIC_NUM_CHANNELS   22
`define CIC_NUM_EXT        15
`define CIC_NUM_GENERAL    11
`define CIC_NUM_BOARD      4
`define CIC_ROUTE_W        5

// Vector bases of the three controllers
`define CIC_VEC_BASE_PRI   8'h40
`define CIC_VEC_BASE_SEC1  8'h48
`define CIC_VEC_BASE_SEC2  8'h50

// Cascade and spurious channels
`define CIC_CASC_SEC1      4'h2
`define CIC_CASC_SEC2      4'h5
`define CIC_SPUR_CH        3'h7
`define CIC_CASC_MASK      8'h24
`define CIC_NONE_IDX       4'h8

// Reset values
`define CIC_ENABLE_RST     15'h0000
`define CIC_VECTOR_RST     8'h00

`endif

// ---- logic/cic_top.v ----
// Cascaded interrupt controller: router, three controllers, vectoring
//
// Contract
// R1: Three controllers, one primary and two secondary, eight channels each.
// R2: Twenty-two priority levels plus a separate non-maskable input.
// R3: Router sends each source to any one of the 22 channels.
// R4: Fifteen external inputs: eleven general pins and four board lines.
// R5: Requests count only on a low-to-high edge of the source.
// R6: An invalid request yields the channel-seven vector.
// R7: A spurious request leaves the channel-seven in-service bit clear.
// R8: Handler clears the in-service bit of its channel when done.
// R9: Highest pending served first; higher priority preempts a lower handler. Not within one secondary: its set cascade bit blocks the request.
// R10: Clear command drops the highest-priority in-service bit.
// R11: External lines start disabled; each enabled or disabled on its own.
// R12: Vector bases 0x40, 0x48, 0x50 plus channel index.
// R13: Secondaries cascade into primary channels two and five.
`timescale 1ns/100ps
`include "cic_defs.vh"

module cic_top #(
  parameter NUM_INT = 7
) (
  // Clock and reset
  input  wire                         ref_clk,
  input  wire                         reset_n,
  // External request pins
  input  wire [10:0]                  general_request_pins,
  input  wire [3:0]                   board_request_lines,
  input  wire                         nmi_pin,
  // Internal peripheral requests
  input  wire [NUM_INT-1:0]           internal_requests,
  // Line enable load
  input  wire                         enable_write,
  input  wire [14:0]                  enable_value,
  // Routing, five bits per source, externals first
  input  wire [(15+NUM_INT)*5-1:0]    source_route,
  // Core side
  input  wire                         int_ack,
  input  wire [2:0]                   clear_top_in_service_command,
  output wire                         intr_req,
  output reg                          nmi_req,
  output reg  [7:0]                   vector_out,
  output reg                          vector_valid,
  output reg                          vector_spurious,
  // In-service bits for handlers
  output wire [7:0]                   primary_in_service,
  output wire [7:0]                   first_secondary_in_service,
  output wire [7:0]                   second_secondary_in_service
);

  localparam NSRC = `CIC_NUM_EXT + NUM_INT;

  reg  [15:0] sync1_reg;
  reg  [15:0] sync2_reg;
  reg  [15:0] sync3_reg;
  reg  [15:0] filt_reg;
  reg  [15:0] filt_next;
  reg         nmi_d_reg;
  reg  [14:0] line_enable_reg;
  reg  [23:0] chan_lvl;
  reg  [NSRC-1:0] src_lvl;
  reg  [7:0]  vector_next;
  reg         spur_next;
  wire        pri_valid;
  wire [2:0]  pri_idx;
  wire        sec1_valid;
  wire [2:0]  sec1_idx;
  wire        sec2_valid;
  wire [2:0]  sec2_idx;
  wire        ack_sec1;
  wire        ack_sec2;
  wire [7:0]  pri_req;

  // Map a router channel number onto a controller slot
  function [4:0] chan_slot;
    input [4:0] sel;
    begin
      case (sel)
        5'h00: chan_slot = 5'h00;
        5'h01: chan_slot = 5'h01;
        5'h02: chan_slot = 5'h03;
        5'h03: chan_slot = 5'h04;
        5'h04: chan_slot = 5'h06;
        5'h05: chan_slot = 5'h07;
        default: chan_slot = sel + 5'h02;
      endcase
    end
  endfunction

  // Three-stage pin synchroniser; a change counts once stages two and
  // three agree, which also rejects a one-cycle glitch
  always @* begin
    filt_next = filt_reg;
    filt_next = (sync2_reg & ~(sync2_reg ^ sync3_reg)) |
                (filt_reg & (sync2_reg ^ sync3_reg));
  end

  always @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      sync1_reg <= 16'h0000;
      sync2_reg <= 16'h0000;
      sync3_reg <= 16'h0000;
      filt_reg  <= 16'h0000;
    end else begin
      sync1_reg <= {nmi_pin, board_request_lines, general_request_pins};
      sync2_reg <= sync1_reg;
      sync3_reg <= sync2_reg;
      filt_reg  <= filt_next;
    end
  end

  // Line enables; all external lines disabled out of reset
  always @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      line_enable_reg <= `CIC_ENABLE_RST; // R11
    end else if (enable_write) begin
      line_enable_reg <= enable_value; // R11
    end
  end

  // Non-maskable input: rising edge gives a one-cycle pulse
  always @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      nmi_d_reg <= 1'b0;
      nmi_req   <= 1'b0;
    end else begin
      nmi_d_reg <= filt_reg[15];
      nmi_req   <= filt_reg[15] & ~nmi_d_reg; // R2
    end
  end

  // Router: source levels, external ones gated by their enables, ORed into their chosen channel.
  // Route values of 22 and above leave a source unconnected.
  always @* begin : route_blk
    integer   s;
    reg [4:0] sel;
    chan_lvl = 24'h000000;
    sel      = 5'h00;
    src_lvl  = {internal_requests,
                filt_reg[14:0] & line_enable_reg}; // R4 R11
    for (s = 0; s < NSRC; s = s + 1) begin
      sel = source_route[s*5 +: 5];
      if (sel < `CIC_NUM_CHANNELS) begin
        chan_lvl[chan_slot(sel)] = chan_lvl[chan_slot(sel)] |
                                   src_lvl[s]; // R3
      end
    end
  end

  // Cascade: secondaries feed primary channels two and five as levels
  assign pri_req = {chan_lvl[7:6], sec2_valid, chan_lvl[4:3],
                    sec1_valid, chan_lvl[1:0]}; // R13

  // Acknowledge reaches a secondary only through its cascade channel
  assign ack_sec1 = int_ack && pri_valid &&
                    ({1'b0, pri_idx} == `CIC_CASC_SEC1); // R13
  assign ack_sec2 = int_ack && pri_valid &&
                    ({1'b0, pri_idx} == `CIC_CASC_SEC2); // R13

  // Primary controller
  cic_unit u_primary (
    .ref_clk    (ref_clk),
    .reset_n    (reset_n),
    .chan_req   (pri_req),
    .level_mask (`CIC_CASC_MASK),
    .ack        (int_ack),
    .eoi        (clear_top_in_service_command[0]),
    .top_valid  (pri_valid),
    .top_idx    (pri_idx),
    .in_service (primary_in_service)
  ); // R1

  // First secondary controller
  cic_unit u_first_secondary (
    .ref_clk    (ref_clk),
    .reset_n    (reset_n),
    .chan_req   (chan_lvl[15:8]),
    .level_mask (8'h00),
    .ack        (ack_sec1),
    .eoi        (clear_top_in_service_command[1]),
    .top_valid  (sec1_valid),
    .top_idx    (sec1_idx),
    .in_service (first_secondary_in_service)
  ); // R1

  // Second secondary controller
  cic_unit u_second_secondary (
    .ref_clk    (ref_clk),
    .reset_n    (reset_n),
    .chan_req   (chan_lvl[23:16]),
    .level_mask (8'h00),
    .ack        (ack_sec2),
    .eoi        (clear_top_in_service_command[2]),
    .top_valid  (sec2_valid),
    .top_idx    (sec2_idx),
    .in_service (second_secondary_in_service)
  ); // R1

  // Interrupt line to the core; combinational handshake
  assign intr_req = pri_valid; // R9

  // Vector choice at acknowledge. A request that vanished before the
  // acknowledge gets the channel-seven vector with no in-service bit
  always @* begin
    vector_next = `CIC_VEC_BASE_PRI + {5'h00, `CIC_SPUR_CH}; // R6
    spur_next   = 1'b1; // R7
    if (pri_valid) begin
      spur_next   = 1'b0;
      vector_next = `CIC_VEC_BASE_PRI + {5'h00, pri_idx}; // R12
      if (ack_sec1) begin
        spur_next   = ~sec1_valid;
        vector_next = sec1_valid ?
                      `CIC_VEC_BASE_SEC1 + {5'h00, sec1_idx} :
                      `CIC_VEC_BASE_SEC1 + {5'h00, `CIC_SPUR_CH}; // R12 R6
      end else if (ack_sec2) begin
        spur_next   = ~sec2_valid;
        vector_next = sec2_valid ?
                      `CIC_VEC_BASE_SEC2 + {5'h00, sec2_idx} :
                      `CIC_VEC_BASE_SEC2 + {5'h00, `CIC_SPUR_CH}; // R12 R6
      end
    end
  end

  // Vector register; answer one cycle after the acknowledge
  always @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      vector_out      <= `CIC_VECTOR_RST;
      vector_valid    <= 1'b0;
      vector_spurious <= 1'b0;
    end else begin
      vector_valid    <= int_ack;
      if (int_ack) begin
        vector_out      <= vector_next;
        vector_spurious <= spur_next;
      end
    end
  end

endmodule // cic_top

// ---- logic/cic_unit.v ----
// One eight-channel controller with request and in-service bits
`timescale 1ns/100ps
`include "cic_defs.vh"

module cic_unit (
  // Clock and reset
  input  wire       ref_clk,
  input  wire       reset_n,
  // Requests, level per channel
  input  wire [7:0] chan_req,
  input  wire [7:0] level_mask,
  // Core commands
  input  wire       ack,
  input  wire       eoi,
  // Resolution
  output wire       top_valid,
  output wire [2:0] top_idx,
  output wire [7:0] in_service
);

  reg  [7:0] req_d_reg;
  reg  [7:0] irr_reg;
  reg  [7:0] irr_next;
  reg  [7:0] isr_reg;
  reg  [7:0] isr_next;
  wire [7:0] pend;
  wire [3:0] p_enc;
  wire [3:0] s_enc;

  // Lowest index wins; 8 means nothing set
  function [3:0] enc8;
    input [7:0] v;
    integer     i;
    begin
      enc8 = `CIC_NONE_IDX;
      for (i = 7; i >= 0; i = i - 1) begin
        if (v[i]) begin
          enc8 = i[3:0];
        end
      end
    end
  endfunction

  // Cascade channels follow the level of the secondary
  assign pend = (irr_reg & ~level_mask) | (chan_req & level_mask);
  assign p_enc = enc8(pend);
  assign s_enc = enc8(isr_reg);
  // Only a request above everything in service is offered
  assign top_valid = (p_enc != `CIC_NONE_IDX) && (p_enc < s_enc); // R9
  assign top_idx = p_enc[2:0];
  assign in_service = isr_reg;

  // Next state of request and in-service bits
  always @* begin
    irr_next = irr_reg;
    isr_next = isr_reg;
    if (eoi && s_enc != `CIC_NONE_IDX) begin
      isr_next[s_enc[2:0]] = 1'b0; // R10
    end
    if (ack && top_valid) begin
      irr_next[p_enc[2:0]] = 1'b0;
      isr_next[p_enc[2:0]] = 1'b1;
    end
    // A fresh edge wins over the acknowledge clear
    irr_next = irr_next | (chan_req & ~req_d_reg & ~level_mask); // R5
  end

  // State registers
  always @(posedge ref_clk or negedge reset_n) begin
    if (!reset_n) begin
      req_d_reg <= 8'h00;
      irr_reg   <= 8'h00;
      isr_reg   <= 8'h00;
    end else begin
      req_d_reg <= chan_req;
      irr_reg   <= irr_next;
      isr_reg   <= isr_next;
    end
  end

endmodule // cic_unit

// ---- verification/cic_core_model.sv ----
// Processor core model that acknowledges the controller's requests
`timescale 1ns/100ps
module cic_core_model (
  // Clock and reset
  input  wire ref_clk,
  input  wire reset_n,
  // Bench controls; force_ack makes an idle acknowledge
  input  wire auto_ack,
  input  wire force_ack,
  // Controller side
  input  wire intr_req,
  output reg  int_ack
);
  // One-cycle ack, then a dead cycle so intr_req can fall first
  always @(negedge ref_clk or negedge reset_n) begin
    if (!reset_n)
      int_ack <= 1'b0;
    else
      int_ack <= (auto_ack && intr_req && !int_ack) || force_ack;
  end
endmodule // cic_core_model

// ---- verification/cic_props.sv ----
// Checker of the controller's core-side behaviour
`timescale 1ns/100ps
module cic_props (
  // Clock and reset
  input wire       ref_clk,
  input wire       reset_n,
  // Core side
  input wire       int_ack,
  input wire [2:0] clear_top_in_service_command,
  input wire       intr_req,
  input wire       nmi_req,
  input wire [7:0] vector_out,
  input wire       vector_valid,
  input wire       vector_spurious,
  input wire [7:0] primary_in_service
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!reset_n);

  a_ack_gives_vector: assert property (int_ack |=> vector_valid)
    else $error("no vector after acknowledge");
  a_vector_has_cause: assert property (vector_valid |-> $past(int_ack))
    else $error("vector without acknowledge");
  a_spur_seven_vec: assert property (
    vector_valid && vector_spurious |-> vector_out[2:0] == 3'h7)
    else $error("spurious vector not channel seven");
  a_spur_no_bit: assert property (
    int_ack && !intr_req && clear_top_in_service_command == 3'h0
    |=> $stable(primary_in_service))
    else $error("idle acknowledge changed in-service");
  a_vector_in_range: assert property (
    vector_valid |-> vector_out inside {[8'h40:8'h57]})
    else $error("vector outside the three bases");
  a_nmi_one_cycle: assert property (nmi_req |=> !nmi_req)
    else $error("nmi request longer than a cycle");
  a_clear_lowest: assert property (
    clear_top_in_service_command[0] && !int_ack && primary_in_service != 0
    |=> primary_in_service == ($past(primary_in_service)
        & ($past(primary_in_service) - 8'h01)))
    else $error("clear did not drop the top in-service bit");
  a_ack_sets_one: assert property (
    int_ack && intr_req && clear_top_in_service_command == 3'h0
    |=> $countones(primary_in_service)
        == $countones($past(primary_in_service)) + 1)
    else $error("acknowledge did not set one in-service bit");

  // Main scenarios reached
  c_spurious: cover property (vector_valid && vector_spurious);
  c_genuine: cover property (vector_valid && !vector_spurious);
  c_nested: cover property (int_ack && intr_req && primary_in_service != 0);
endmodule // cic_props

bind cic_top cic_props u_props (
  .ref_clk, .reset_n, .int_ack, .clear_top_in_service_command, .intr_req,
  .nmi_req, .vector_out, .vector_valid, .vector_spurious, .primary_in_service);

// ---- verification/cic_tb_top.sv ----
// Self-checking bench of the cascaded interrupt controller
`timescale 1ns/100ps
module cic_tb_top;
  reg          ref_clk, reset_n, nmi_pin, enable_write, auto_ack, force_ack;
  reg  [14:0]  ext_pins;
  reg  [6:0]   int_src;
  reg  [14:0]  enable_value;
  reg  [109:0] source_route;
  reg  [2:0]   clr;
  wire         int_ack, intr_req, nmi_req, vector_valid, vector_spurious;
  wire [7:0]   vector_out, pri_isr, sec1_isr, sec2_isr;
  integer      errors, n_compared;

  cic_top #(.NUM_INT(7)) dut_u (
    .ref_clk(ref_clk), .reset_n(reset_n),
    .general_request_pins(ext_pins[10:0]),
    .board_request_lines(ext_pins[14:11]), .nmi_pin(nmi_pin),
    .internal_requests(int_src), .enable_write(enable_write),
    .enable_value(enable_value), .source_route(source_route),
    .int_ack(int_ack), .clear_top_in_service_command(clr),
    .intr_req(intr_req), .nmi_req(nmi_req), .vector_out(vector_out),
    .vector_valid(vector_valid), .vector_spurious(vector_spurious),
    .primary_in_service(pri_isr), .first_secondary_in_service(sec1_isr),
    .second_secondary_in_service(sec2_isr));

  cic_core_model core_u (.ref_clk(ref_clk), .reset_n(reset_n),
    .auto_ack(auto_ack), .force_ack(force_ack), .intr_req(intr_req),
    .int_ack(int_ack));

  initial begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end

  task chk(input [7:0] seen, input [7:0] exp);
    begin
      n_compared = n_compared + 1;
      if (seen !== exp) begin
        errors = errors + 1;
        $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
      end
    end
  endtask

  task print_verdict;
    begin
      $display("compared %0d errors %0d", n_compared, errors);
      if (errors == 0 && n_compared > 0)
        $display("SIMULATION PASSED");
      else
        $display("SIMULATION FAILED");
      $finish;
    end
  endtask

  // Pins are async; each level is held three cycles
  task pin(input integer b, input lvl);
    begin
      ext_pins[b] = lvl;
      repeat (3) @(negedge ref_clk);
    end
  endtask

  task pulse_clr(input [2:0] c);
    begin
      clr = c;
      @(negedge ref_clk);
      clr = 3'h0;
      @(negedge ref_clk);
    end
  endtask

  task get_vec(input [7:0] exp, input sp);
    integer i;
    begin
      for (i = 0; i < 30 && vector_valid !== 1'b1; i = i + 1)
        @(negedge ref_clk);
      chk({7'h00, vector_valid}, 8'h01);
      chk(vector_out, exp);
      chk({7'h00, vector_spurious}, {7'h00, sp});
    end
  endtask

  task set_enables(input [14:0] v);
    begin
      enable_value = v;
      enable_write = 1'b1;
      @(negedge ref_clk);
      enable_write = 1'b0;
    end
  endtask

  // Reset state, and an edge on a line not yet enabled is lost
  task t_reset;
    begin
      chk(pri_isr, 8'h00);
      source_route[0+:5] = 5'd0;
      pin(0, 1'b1);
      repeat (10) @(negedge ref_clk);
      chk({7'h00, intr_req}, 8'h00);
      pin(0, 1'b0);
    end
  endtask

  // One routed pin through to its vector, then the handler's clear
  task do_one(input integer b, input [4:0] ch, input [7:0] vec,
              input [7:0] pisr, input [7:0] s1, input [7:0] s2,
              input [2:0] c);
    begin
      source_route[b*5+:5] = ch;
      pin(b, 1'b1);
      get_vec(vec, 1'b0);
      chk(pri_isr, pisr);
      chk(sec1_isr, s1);
      chk(sec2_isr, s2);
      pulse_clr(c);
      chk(pri_isr, 8'h00);
      chk(sec1_isr, 8'h00);
      chk(sec2_isr, 8'h00);
      pin(b, 1'b0);
    end
  endtask

  task t_vectors;
    begin
      set_enables(15'h7FFF);
      auto_ack = 1'b1;
      do_one(1, 5'd0, 8'h40, 8'h01, 8'h00, 8'h00, 3'h1);
      do_one(4, 5'd13, 8'h4F, 8'h04, 8'h80, 8'h00, 3'h3);
      do_one(7, 5'd14, 8'h50, 8'h20, 8'h00, 8'h01, 3'h5);
      do_one(11, 5'd2, 8'h43, 8'h08, 8'h00, 8'h00, 3'h1);
    end
  endtask

  // Acknowledge with nothing pending
  task t_spurious;
    begin
      // Nonblocking, so the model on the same edge never races the bench
      force_ack <= 1'b1;
      @(negedge ref_clk);
      force_ack <= 1'b0;
      get_vec(8'h47, 1'b1);
      chk(pri_isr, 8'h00);
    end
  endtask

  // Lowest channel in service, then preempted by the highest
  task t_nested;
    integer i;
    begin
      source_route[2*5+:5] = 5'd5;
      source_route[3*5+:5] = 5'd0;
      pin(2, 1'b1);
      get_vec(8'h47, 1'b0);
      chk(pri_isr, 8'h80);
      pin(3, 1'b1);
      get_vec(8'h40, 1'b0);
      chk(pri_isr, 8'h81);
      pulse_clr(3'h1);
      chk(pri_isr, 8'h80);
      repeat (10) @(negedge ref_clk);
      chk({7'h00, intr_req}, 8'h00);
      chk(pri_isr, 8'h80);
      pulse_clr(3'h1);
      chk(pri_isr, 8'h00);
      nmi_pin = 1'b1;
      for (i = 0; i < 20 && nmi_req !== 1'b1; i = i + 1)
        @(negedge ref_clk);
      chk({7'h00, nmi_req}, 8'h01);
    end
  endtask

  // Disabling again blocks a fresh edge
  task t_disable;
    begin
      set_enables(15'h0000);
      pin(4, 1'b1);
      repeat (10) @(negedge ref_clk);
      chk({7'h00, intr_req}, 8'h00);
      chk(pri_isr, 8'h00);
      chk(sec1_isr, 8'h00);
    end
  endtask

  // Internal source: no enable and no synchroniser in its path
  task t_internal;
    begin
      source_route[15*5+:5] = 5'd1;
      int_src = 7'h01;
      get_vec(8'h41, 1'b0);
      chk(pri_isr, 8'h02);
      pulse_clr(3'h1);
      chk(pri_isr, 8'h00);
      int_src = 7'h00;
    end
  endtask

  // Watchdog, well above the roughly 125 cycles the tests take
  initial begin
    #20000;
    errors = errors + 1;
    print_verdict;
  end

  initial begin
    errors = 0;
    n_compared = 0;
    reset_n = 1'b0;
    nmi_pin = 1'b0;
    enable_write = 1'b0;
    auto_ack = 1'b0;
    force_ack = 1'b0;
    ext_pins = 15'h0000;
    int_src = 7'h00;
    enable_value = 15'h0000;
    source_route = {110{1'b1}};
    clr = 3'h0;
    repeat (12) @(negedge ref_clk);
    reset_n = 1'b1;
    t_reset;
    t_vectors;
    t_spurious;
    t_nested;
    t_disable;
    t_internal;
    print_verdict;
  end
endmodule // cic_tb_top
